//--- inc/ssp_pkg.sv
package ssp_pkg;

  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ACK, ST_RX, ST_TX, ST_MACK} ssp_state_t;

  typedef enum logic [1:0] {REQ_READ, REQ_WRITE, REQ_RESET} ssp_req_t;

  // Bus addressing
  localparam logic [6:0] OWN_ADDR     = 7'h48;
  localparam logic [6:0] GC_ADDR      = 7'h00;
  localparam logic [7:0] GC_RESET_CMD = 8'h06;
  localparam logic [7:0] RESET_PTR    = 8'hbf;
  localparam logic [7:0] STATUS_PTR   = 8'h00;

  // Register map
  localparam int         MAP_SIZE    = 32;
  localparam int         RO_COUNT    = 9;
  localparam logic [7:0] WR_LO       = 8'h09;
  localparam logic [7:0] WR_HI       = 8'h12;
  localparam int         WR_COUNT    = 10;
  localparam logic [7:0] SERIAL_LO   = 8'h13;
  localparam int         SERIAL_LEN  = 4;
  localparam logic [7:0] DEVICE_IDENTIFICATION_PTR = 8'h17;

  // Defaults of the writable bytes, lowest address in the lowest byte
  localparam logic [8*WR_COUNT-1:0] WR_DEFAULTS = {8'hc0, 8'hc0, 8'h40, 56'h0};

  // Default reload time
  localparam int RESET_TIME_US = 2000;
  localparam int CLK_MHZ       = 100;
  localparam int RESET_CYCLES  = RESET_TIME_US * CLK_MHZ;

endpackage : ssp_pkg

//--- rtl/ssp_sync.sv
`timescale 1ns/1ps
module ssp_sync #(
  parameter int W = 1
) (
  // Destination clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  // Crossing data
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  logic [W-1:0] meta_r;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_r <= '0;
      q_out  <= '0;
    end else begin
      meta_r <= d_in;
      q_out  <= meta_r;
    end
  end

endmodule : ssp_sync

//--- rtl/ssp_port.sv
`timescale 1ns/1ps
// Summary of operation
// - Start is SDA falling while SCL high.
// - Start byte: 7-bit address plus direction, MSB first.
// - Acknowledge own address; otherwise withdraw to idle.
// - Direction 0 receives, direction 1 transmits.
// - Answer start bytes 0x90 write, 0x91 read.
// - Read shifts pointed register, then samples acknowledge.
// - Master ack increments pointer; no ack idles.
// - Pointer register itself is never readable.
// - Reads past 0x17 return zero up to 0x1F, then wrap.
// - Stop after read returns pointer to status.
// - Invalid-address writes discarded, still acknowledged.
// - First written byte loads pointer, acknowledged.
// - Stop after pointer byte idles, clears pointer.
// - Stop is SDA rising while SCL high.
// - Data bytes store at pointer, pointer increments.
// - Repeated start handled exactly as a start.
// - Pointer word 0xBF reloads all defaults.
// - No acknowledge for about 2 ms during reload.
// - General call acknowledged, command byte received.
// - General call 0x06 resets; others unacknowledged.
// - Serial number 0x13-0x16, identification at 0x17.
module ssp_port #(
  parameter int          RESET_CYCLES  = ssp_pkg::RESET_CYCLES,
  parameter logic [31:0] SERIAL_NUMBER = 32'h1234_5678, // Arbitrary value
  parameter logic [7:0]  DEVICE_IDENTIFICATION       = 8'h5a          // Arbitrary value
) (
  // System clock and reset
  input  wire logic                          ref_clk_in,
  input  wire logic                          rst_n_in,
  // Two-wire link
  input  wire logic                          link_clk_in,
  input  wire logic                          scl_in,
  input  wire logic                          sda_in,
  output logic                               sda_out,
  output logic                               sda_oe_out,
  // Measurement core side
  input  wire logic [8*ssp_pkg::RO_COUNT-1:0] core_status_in,
  output logic      [8*ssp_pkg::WR_COUNT-1:0] cfg_regs_out,
  output logic                               core_reset_out
);

  localparam int CNT_W = $clog2(RESET_CYCLES + 1);

  if (RESET_CYCLES < 1) begin : g_bad_cycles
    $error("RESET_CYCLES must be at least one");
  end

  // Link domain state
  logic                link_rst_n;
  logic [1:0]          pins_s;
  logic [1:0]          back_s;
  logic                scl_s;
  logic                sda_s;
  logic                busy_s;
  logic                ack_s;
  logic                scl_d_r;
  logic                sda_d_r;
  ssp_pkg::ssp_state_t state_r;
  ssp_pkg::ssp_state_t state_nxt;
  logic [2:0]          bit_cnt_r;
  logic [2:0]          bit_cnt_nxt;
  logic [7:0]          shift_r;
  logic [7:0]          shift_nxt;
  logic [7:0]          ptr_r;
  logic [7:0]          ptr_nxt;
  logic                ptr_ok_r;
  logic                ptr_ok_nxt;
  logic                gc_r;
  logic                gc_nxt;
  logic                rw_r;
  logic                rw_nxt;
  logic                done_r;
  logic                done_nxt;
  logic                phase_r;
  logic                phase_nxt;
  logic                sda_low_r;
  logic                sda_low_nxt;
  logic                req_go;
  logic                req_tgl_r;
  ssp_pkg::ssp_req_t   req_kind_r;
  ssp_pkg::ssp_req_t   req_kind_nxt;
  logic [7:0]          req_addr_r;
  logic [7:0]          req_addr_nxt;
  logic [7:0]          req_data_r;
  logic [7:0]          req_data_nxt;

  // Reference domain state
  logic                         req_s;
  logic                         req_seen_r;
  logic                         busy_r;
  logic [CNT_W-1:0]             busy_cnt_r;
  logic [7:0]                   rd_data_r;
  logic [8*ssp_pkg::WR_COUNT-1:0] cfg_r;
  logic [7:0]                   map_w [ssp_pkg::MAP_SIZE];

  // Reset release is synchronised so the link logic leaves reset cleanly
  ssp_sync #(.W(1)) u_link_rst (
    .clk_in   (link_clk_in),
    .rst_n_in (rst_n_in),
    .d_in     (1'b1),
    .q_out    (link_rst_n)
  );

  // Pins cross inverted so the synchroniser's reset value reads as an idle
  // bus and no false edge follows reset
  ssp_sync #(.W(2)) u_pin_sync (
    .clk_in   (link_clk_in),
    .rst_n_in (link_rst_n),
    .d_in     ({~scl_in, ~sda_in}),
    .q_out    (pins_s)
  );

  ssp_sync #(.W(2)) u_back_sync (
    .clk_in   (link_clk_in),
    .rst_n_in (link_rst_n),
    .d_in     ({busy_r, req_seen_r}),
    .q_out    (back_s)
  );

  ssp_sync #(.W(1)) u_req_sync (
    .clk_in   (ref_clk_in),
    .rst_n_in (rst_n_in),
    .d_in     (req_tgl_r),
    .q_out    (req_s)
  );

  assign scl_s  = ~pins_s[1];
  assign sda_s  = ~pins_s[0];
  assign busy_s = back_s[1];
  assign ack_s  = back_s[0];

  wire       start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire       stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;
  wire       scl_rise  = scl_s & ~scl_d_r;
  wire       scl_fall  = ~scl_s & scl_d_r;
  wire [7:0] rx_byte   = {shift_r[6:0], sda_s};
  wire       byte_done = scl_rise & (bit_cnt_r == 3'd7);
  wire       gc_hit    = rx_byte == {ssp_pkg::GC_ADDR, 1'b0};
  wire       addr_ok   = (rx_byte[7:1] == ssp_pkg::OWN_ADDR) | gc_hit;

  // Open drain: the pad only ever pulls low; SCL is input only
  assign sda_out    = 1'b0;
  assign sda_oe_out = sda_low_r;

  always_comb begin
    state_nxt    = state_r;
    bit_cnt_nxt  = bit_cnt_r;
    shift_nxt    = shift_r;
    ptr_nxt      = ptr_r;
    ptr_ok_nxt   = ptr_ok_r;
    gc_nxt       = gc_r;
    rw_nxt       = rw_r;
    done_nxt     = done_r;
    phase_nxt    = phase_r;
    sda_low_nxt  = sda_low_r;
    req_go       = 1'b0;
    req_kind_nxt = req_kind_r;
    req_addr_nxt = req_addr_r;
    req_data_nxt = req_data_r;
    if (stop_det) begin
      state_nxt   = ssp_pkg::ST_IDLE;
      sda_low_nxt = 1'b0;
      ptr_nxt     = ssp_pkg::STATUS_PTR;
    end else if (start_det) begin
      // Repeated start keeps the pointer for a following read
      state_nxt   = ssp_pkg::ST_ADDR;
      bit_cnt_nxt = 3'd0;
      sda_low_nxt = 1'b0;
      ptr_ok_nxt  = 1'b0;
      gc_nxt      = 1'b0;
      done_nxt    = 1'b0;
    end else begin
      case (state_r)
        ssp_pkg::ST_ADDR: begin
          if (scl_rise) begin
            shift_nxt   = rx_byte;
            bit_cnt_nxt = bit_cnt_r + 3'd1;
            if (bit_cnt_r == 3'd7) begin
              if (!addr_ok || busy_s) begin
                state_nxt = ssp_pkg::ST_IDLE;
              end else begin
                state_nxt = ssp_pkg::ST_ACK;
                phase_nxt = 1'b0;
                rw_nxt    = rx_byte[0];
                gc_nxt    = gc_hit;
                if (rx_byte[0]) begin
                  req_go       = 1'b1;
                  req_kind_nxt = ssp_pkg::REQ_READ;
                  req_addr_nxt = ptr_r;
                end
              end
            end
          end
        end
        ssp_pkg::ST_ACK: begin
          if (scl_fall) begin
            if (!phase_r) begin
              phase_nxt   = 1'b1;
              sda_low_nxt = 1'b1;
            end else begin
              phase_nxt   = 1'b0;
              bit_cnt_nxt = 3'd0;
              sda_low_nxt = 1'b0;
              if (done_r) begin
                state_nxt = ssp_pkg::ST_IDLE;
              end else if (rw_r) begin
                state_nxt   = ssp_pkg::ST_TX;
                shift_nxt   = {rd_data_r[6:0], 1'b0};
                sda_low_nxt = ~rd_data_r[7];
              end else begin
                state_nxt = ssp_pkg::ST_RX;
              end
            end
          end
        end
        ssp_pkg::ST_RX: begin
          if (scl_rise) begin
            shift_nxt   = rx_byte;
            bit_cnt_nxt = bit_cnt_r + 3'd1;
            if (bit_cnt_r == 3'd7) begin
              state_nxt = ssp_pkg::ST_ACK;
              phase_nxt = 1'b0;
              if (gc_r) begin
                if (rx_byte == ssp_pkg::GC_RESET_CMD) begin
                  done_nxt     = 1'b1;
                  req_go       = 1'b1;
                  req_kind_nxt = ssp_pkg::REQ_RESET;
                  ptr_nxt      = ssp_pkg::STATUS_PTR;
                end else begin
                  state_nxt = ssp_pkg::ST_IDLE;
                end
              end else if (!ptr_ok_r) begin
                if (rx_byte == ssp_pkg::RESET_PTR) begin
                  done_nxt     = 1'b1;
                  req_go       = 1'b1;
                  req_kind_nxt = ssp_pkg::REQ_RESET;
                  ptr_nxt      = ssp_pkg::STATUS_PTR;
                end else begin
                  ptr_nxt    = rx_byte;
                  ptr_ok_nxt = 1'b1;
                end
              end else begin
                // Range check is in the reference domain; the byte is acked anyway
                req_go       = 1'b1;
                req_kind_nxt = ssp_pkg::REQ_WRITE;
                req_addr_nxt = ptr_r;
                req_data_nxt = rx_byte;
                ptr_nxt      = ptr_r + 8'h01;
              end
            end
          end
        end
        ssp_pkg::ST_TX: begin
          if (scl_fall) begin
            sda_low_nxt = ~shift_r[7];
            shift_nxt   = {shift_r[6:0], 1'b0};
          end
          if (scl_rise) begin
            bit_cnt_nxt = bit_cnt_r + 3'd1;
            phase_nxt   = 1'b0;
            if (bit_cnt_r == 3'd7) begin
              state_nxt = ssp_pkg::ST_MACK;
            end
          end
        end
        ssp_pkg::ST_MACK: begin
          if (scl_fall && !phase_r) begin
            sda_low_nxt = 1'b0;
          end
          if (scl_rise) begin
            if (sda_s) begin
              state_nxt = ssp_pkg::ST_IDLE;
            end else begin
              phase_nxt    = 1'b1;
              ptr_nxt      = ptr_r + 8'h01;
              req_go       = 1'b1;
              req_kind_nxt = ssp_pkg::REQ_READ;
              req_addr_nxt = ptr_r + 8'h01;
            end
          end
          if (scl_fall && phase_r) begin
            state_nxt   = ssp_pkg::ST_TX;
            phase_nxt   = 1'b0;
            bit_cnt_nxt = 3'd0;
            shift_nxt   = {rd_data_r[6:0], 1'b0};
            sda_low_nxt = ~rd_data_r[7];
          end
        end
        default: begin
          state_nxt = ssp_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge link_clk_in or negedge link_rst_n) begin
    if (!link_rst_n) begin
      scl_d_r    <= 1'b1;
      sda_d_r    <= 1'b1;
      state_r    <= ssp_pkg::ST_IDLE;
      bit_cnt_r  <= 3'd0;
      shift_r    <= 8'h00;
      ptr_r      <= ssp_pkg::STATUS_PTR;
      ptr_ok_r   <= 1'b0;
      gc_r       <= 1'b0;
      rw_r       <= 1'b0;
      done_r     <= 1'b0;
      phase_r    <= 1'b0;
      sda_low_r  <= 1'b0;
      req_tgl_r  <= 1'b0;
      req_kind_r <= ssp_pkg::REQ_READ;
      req_addr_r <= 8'h00;
      req_data_r <= 8'h00;
    end else begin
      scl_d_r    <= scl_s;
      sda_d_r    <= sda_s;
      state_r    <= state_nxt;
      bit_cnt_r  <= bit_cnt_nxt;
      shift_r    <= shift_nxt;
      ptr_r      <= ptr_nxt;
      ptr_ok_r   <= ptr_ok_nxt;
      gc_r       <= gc_nxt;
      rw_r       <= rw_nxt;
      done_r     <= done_nxt;
      phase_r    <= phase_nxt;
      sda_low_r  <= sda_low_nxt;
      req_tgl_r  <= req_tgl_r ^ req_go;
      req_kind_r <= req_kind_nxt;
      req_addr_r <= req_addr_nxt;
      req_data_r <= req_data_nxt;
    end
  end

  // Request fields are stable from the toggle until the next one, so the
  // reference side samples them only after the toggle has crossed
  wire new_req  = req_s ^ req_seen_r;
  wire do_read  = new_req & (req_kind_r == ssp_pkg::REQ_READ);
  wire do_write = new_req & (req_kind_r == ssp_pkg::REQ_WRITE) & ~busy_r;
  wire do_reset = new_req & (req_kind_r == ssp_pkg::REQ_RESET);
  wire wr_ok    = (req_addr_r >= ssp_pkg::WR_LO) && (req_addr_r <= ssp_pkg::WR_HI);

  // Read map wraps every 32 pointer values; the pointer itself is absent
  for (genvar i = 0; i < ssp_pkg::MAP_SIZE; i++) begin : g_map
    if (i < ssp_pkg::RO_COUNT) begin : g_ro
      assign map_w[i] = core_status_in[8*i +: 8];
    end else if (i >= ssp_pkg::WR_LO && i <= ssp_pkg::WR_HI) begin : g_wr
      assign map_w[i] = cfg_r[8*(i-ssp_pkg::WR_LO) +: 8];
    end else if (i >= ssp_pkg::SERIAL_LO && i < ssp_pkg::SERIAL_LO + ssp_pkg::SERIAL_LEN)
    begin : g_sn
      assign map_w[i] = SERIAL_NUMBER[8*(ssp_pkg::SERIAL_LO+ssp_pkg::SERIAL_LEN-1-i) +: 8];
    end else if (i == ssp_pkg::DEVICE_IDENTIFICATION_PTR) begin : g_id
      assign map_w[i] = DEVICE_IDENTIFICATION;
    end else begin : g_zero
      assign map_w[i] = 8'h00;
    end
  end

  for (genvar i = 0; i < ssp_pkg::WR_COUNT; i++) begin : g_cfg
    wire hit = do_write && wr_ok && (req_addr_r == 8'(ssp_pkg::WR_LO + i));
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        cfg_r[8*i +: 8] <= ssp_pkg::WR_DEFAULTS[8*i +: 8];
      end else if (do_reset) begin
        cfg_r[8*i +: 8] <= ssp_pkg::WR_DEFAULTS[8*i +: 8];
      end else if (hit) begin
        cfg_r[8*i +: 8] <= req_data_r;
      end
    end
  end

  assign cfg_regs_out   = cfg_r;
  assign core_reset_out = busy_r;

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      req_seen_r <= 1'b0;
      rd_data_r  <= 8'h00;
      busy_r     <= 1'b0;
      busy_cnt_r <= '0;
    end else begin
      req_seen_r <= req_s;
      if (do_read) begin
        rd_data_r <= map_w[req_addr_r[4:0]];
      end
      if (do_reset) begin
        busy_r     <= 1'b1;
        busy_cnt_r <= CNT_W'(RESET_CYCLES - 1);
      end else if (busy_r) begin
        busy_cnt_r <= busy_cnt_r - 1'b1;
        busy_r     <= busy_cnt_r != '0;
      end
    end
  end

  a_start_addr: assert property (
    @(posedge link_clk_in) disable iff (!link_rst_n)
    start_det |=> state_r == ssp_pkg::ST_ADDR && bit_cnt_r == 3'd0)
    else $error("start condition not taken");

  a_addr_nack: assert property (
    @(posedge link_clk_in) disable iff (!link_rst_n)
    state_r == ssp_pkg::ST_ADDR && byte_done && !addr_ok
    |=> state_r == ssp_pkg::ST_IDLE ##1 !sda_oe_out)
    else $error("foreign address not ignored");

  a_ack_drive: assert property (
    @(posedge link_clk_in) disable iff (!link_rst_n)
    state_r == ssp_pkg::ST_ACK && !phase_r && scl_fall |=> sda_oe_out && !sda_out)
    else $error("acknowledge not driven");

  a_write_dir: assert property (
    @(posedge link_clk_in) disable iff (!link_rst_n)
    state_r == ssp_pkg::ST_ADDR && byte_done && !busy_s
    && rx_byte == {ssp_pkg::OWN_ADDR, 1'b0}
    |=> state_r == ssp_pkg::ST_ACK && !rw_r)
    else $error("write address not accepted");

  a_read_dir: assert property (
    @(posedge link_clk_in) disable iff (!link_rst_n)
    state_r == ssp_pkg::ST_ADDR && byte_done && !busy_s
    && rx_byte == {ssp_pkg::OWN_ADDR, 1'b1}
    |=> rw_r && req_kind_r == ssp_pkg::REQ_READ && req_addr_r == $past(ptr_r))
    else $error("read address not accepted");

  a_busy_nack: assert property (
    @(posedge link_clk_in) disable iff (!link_rst_n)
    state_r == ssp_pkg::ST_ADDR && byte_done && busy_s |=> state_r == ssp_pkg::ST_IDLE)
    else $error("acknowledged during reload");

  a_mack_incr: assert property (
    @(posedge link_clk_in) disable iff (!link_rst_n)
    state_r == ssp_pkg::ST_MACK && scl_rise && !sda_s |=> ptr_r == $past(ptr_r) + 8'h01)
    else $error("pointer not advanced on master ack");

  a_nack_hold: assert property (
    @(posedge link_clk_in) disable iff (!link_rst_n)
    state_r == ssp_pkg::ST_MACK && scl_rise && sda_s
    |=> state_r == ssp_pkg::ST_IDLE && $stable(ptr_r))
    else $error("no-ack handling wrong");

  a_stop_ptr: assert property (
    @(posedge link_clk_in) disable iff (!link_rst_n)
    stop_det |=> state_r == ssp_pkg::ST_IDLE && ptr_r == ssp_pkg::STATUS_PTR)
    else $error("stop did not clear pointer");

  a_ptr_load: assert property (
    @(posedge link_clk_in) disable iff (!link_rst_n)
    state_r == ssp_pkg::ST_RX && byte_done && !ptr_ok_r && !gc_r
    && rx_byte != ssp_pkg::RESET_PTR |=> ptr_r == $past(rx_byte) && ptr_ok_r)
    else $error("pointer byte not loaded");

  a_gc_nack: assert property (
    @(posedge link_clk_in) disable iff (!link_rst_n)
    state_r == ssp_pkg::ST_RX && gc_r && byte_done && rx_byte != ssp_pkg::GC_RESET_CMD
    |=> state_r == ssp_pkg::ST_IDLE)
    else $error("general call command wrongly taken");

  a_read_ready: assert property (
    @(posedge link_clk_in) disable iff (!link_rst_n)
    state_r == ssp_pkg::ST_ACK && phase_r && rw_r && !done_r && scl_fall |-> ack_s == req_tgl_r)
    else $error("read data not ready at load");

  a_reset_busy: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    do_reset |=> busy_r && cfg_r == ssp_pkg::WR_DEFAULTS)
    else $error("reset command not applied");

  a_bad_write: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    do_write && !wr_ok && !do_reset |=> $stable(cfg_r))
    else $error("invalid write changed a register");

endmodule : ssp_port

//--- test/ssp_master_model.sv
`timescale 1ns/1ps
module ssp_master_model (
  // Pacing clock
  input  wire logic clk_in,
  // Two-wire bus
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_oe_out
);
  // 380 ns phases stay above the 30 link-clock minimum the fetch needs
  task automatic hp;
    repeat (38) @(posedge clk_in);
    #1;
  endtask : hp
  initial begin
    scl_out    = 1'b1;
    sda_oe_out = 1'b0;
  end
  // Also serves as repeated start
  task automatic s_start;
    hp();
    sda_oe_out = 1'b0;
    hp();
    scl_out = 1'b1;
    hp();
    sda_oe_out = 1'b1;
    hp();
    scl_out = 1'b0;
  endtask : s_start
  task automatic s_stop;
    hp();
    sda_oe_out = 1'b1;
    hp();
    scl_out = 1'b1;
    hp();
    sda_oe_out = 1'b0;
    hp();
  endtask : s_stop
  // SDA moves one phase after the SCL fall, never beside it
  task automatic bit_x(input logic b, output logic r);
    hp();
    sda_oe_out = ~b;
    hp();
    scl_out = 1'b1;
    hp();
    r = sda_in;
    scl_out = 1'b0;
  endtask : bit_x
  task automatic wr(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(v[i], r);
    bit_x(1'b1, r);
    ack = ~r;
  endtask : wr
  task automatic rd(input logic ack, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, v[i]);
    bit_x(~ack, r);
  endtask : rd
endmodule : ssp_master_model

//--- test/testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam int          RST_CYC = 2000;
  localparam logic [31:0] SER_NUM = 32'ha5c3_1e07; // Arbitrary value
  localparam logic [7:0]  DEV_ID  = 8'h3c;         // Arbitrary value
  logic        ref_clk  = 1'b0;
  logic        link_clk = 1'b0;
  logic        rst_n;
  logic        scl;
  logic        m_oe;
  logic        sda_out;
  logic        sda_oe;
  logic        core_reset;
  logic [71:0] status;
  logic [79:0] cfg;
  wire         sda_w = ~m_oe & (sda_oe ? sda_out : 1'b1);
  int          err_total = 0;
  int          comparisons = 0;
  int          seed = 25;
  logic [7:0]  wr_m [10];
  logic [7:0]  v;
  logic        a;
  logic [7:0]  bad [3] = '{8'h92, 8'h01, 8'h10};
  always #5 ref_clk = ~ref_clk;
  initial #2.3 forever #6 link_clk = ~link_clk;
  ssp_port #(.RESET_CYCLES(RST_CYC), .SERIAL_NUMBER(SER_NUM), .DEVICE_IDENTIFICATION(DEV_ID)) dut_u (
    .ref_clk_in(ref_clk), .rst_n_in(rst_n), .link_clk_in(link_clk), .scl_in(scl),
    .sda_in(sda_w), .sda_out(sda_out), .sda_oe_out(sda_oe), .core_status_in(status),
    .cfg_regs_out(cfg), .core_reset_out(core_reset));
  ssp_master_model mst_u (.clk_in(ref_clk), .sda_in(sda_w), .scl_out(scl), .sda_oe_out(m_oe));
  function automatic logic [79:0] packed_cfg();
    logic [79:0] p;
    for (int i = 0; i < 10; i++) p[8*i +: 8] = wr_m[i];
    return p;
  endfunction : packed_cfg
  function automatic logic [7:0] exp_rd(input int p);
    int q;
    q = p % 32;
    if (q < 9) return status[8*q +: 8];
    if (q < 19) return wr_m[q-9];
    if (q < 23) return SER_NUM[8*(22-q) +: 8];
    if (q == 23) return DEV_ID;
    return 8'h00;
  endfunction : exp_rd
  task automatic end_sim;
    $display("err_total=%0d comparisons=%0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wa(input logic [7:0] b, input logic e);
    mst_u.wr(b, a);
    chk(80'(a), 80'(e));
  endtask : wa
  task automatic rb(input int p, input logic ack);
    mst_u.rd(ack, v);
    chk(80'(v), 80'(exp_rd(p)));
  endtask : rb
  task automatic sp(input logic [7:0] p);
    mst_u.s_start();
    wa(8'h90, 1'b1);
    wa(p, 1'b1);
  endtask : sp
  task automatic defaults;
    for (int i = 0; i < 10; i++) wr_m[i] = ssp_pkg::WR_DEFAULTS[8*i +: 8];
  endtask : defaults
  initial begin
    repeat (90000) @(posedge ref_clk);
    err_total++;
    end_sim();
  end
  initial begin
    rst_n  = 1'b0;
    status = '0;
    defaults();
    repeat (12) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    for (int i = 0; i < 9; i++) status[8*i +: 8] = 8'($random(seed));
    repeat (20) @(posedge ref_clk);
    chk(cfg, packed_cfg());
    chk(80'(sda_out), 80'h0);
    sp(8'h09);
    for (int i = 0; i < 11; i++) begin
      v = 8'($random(seed));
      wa(v, 1'b1);
      if (i < 10) wr_m[i] = v;
    end
    mst_u.s_stop();
    chk(cfg, packed_cfg());
    sp(8'h10);
    mst_u.s_start();
    wa(8'h91, 1'b1);
    for (int p = 16; p < 25; p++) rb(p, p < 24);
    mst_u.s_stop();
    sp(8'h11);
    repeat (2) begin
      mst_u.s_start();
      wa(8'h91, 1'b1);
      rb(17, 1'b0);
    end
    mst_u.s_stop();
    mst_u.s_start();
    wa(8'h91, 1'b1);
    rb(0, 1'b0);
    mst_u.s_stop();
    sp(8'h1f);
    mst_u.s_stop();
    mst_u.s_start();
    wa(8'h91, 1'b1);
    rb(0, 1'b0);
    mst_u.s_stop();
    foreach (bad[i]) begin
      mst_u.s_start();
      wa(bad[i], 1'b0);
      mst_u.s_stop();
    end
    mst_u.s_start();
    wa(8'h00, 1'b1);
    wa(8'h05, 1'b0);
    mst_u.s_stop();
    for (int k = 0; k < 2; k++) begin
      sp(8'h12);
      v = 8'($random(seed));
      wa(v, 1'b1);
      wr_m[9] = v;
      mst_u.s_stop();
      mst_u.s_start();
      wa(k ? 8'h00 : 8'h90, 1'b1);
      wa(k ? 8'h06 : 8'hbf, 1'b1);
      mst_u.s_stop();
      chk(80'(core_reset), 80'h1);
      mst_u.s_start();
      wa(8'h90, 1'b0);
      mst_u.s_stop();
      repeat (RST_CYC) @(posedge ref_clk);
      defaults();
      chk(80'(core_reset), 80'h0);
      chk(cfg, packed_cfg());
    end
    end_sim();
  end
endmodule : testbench
